/* hw/fcb_pkg.sv */
package fcb_pkg;
  // Command codes seen on the decoded instruction port
  localparam logic [7:0] OP_READ_ANY = 8'h65; // Register read
  localparam logic [7:0] OP_WRITE_ANY = 8'h71; // Register write
  localparam logic [7:0] OP_RESUME_OR_CLR = 8'h30; // Dual-meaning code
  localparam logic [7:0] OP_LEGACY_RST = 8'hF0; // Single-byte reset
  localparam logic [7:0] OP_RST_ENABLE = 8'h66; // Reset enable
  localparam logic [7:0] OP_RST_EXEC = 8'h99; // Reset execute
  // Register addresses in the register address space
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_CFG_NV = 24'h000004; // Boot copy
  localparam logic [ADDR_W-1:0] ADDR_CFG_V = 24'h800004; // Working copy
  // Field positions
  localparam int BIT_BLANK = 5;
  localparam int BIT_WRAP = 4;
  localparam int BIT_SMALL = 3;
  localparam int BIT_RESUME = 2;
  localparam int BIT_LEGACY = 0;
  // Implemented bits, bits software may write in the working copy, reset value
  localparam logic [7:0] CFG_USED_MASK = 8'h3D;
  localparam logic [7:0] V_WRITE_MASK = 8'h35;
  localparam logic [7:0] NV_RESET = 8'h00;
  // Page buffer geometry
  localparam int PAGE_AW = 9;
  localparam int PAGE_DEPTH = 512;
  // Erase kinds and blank check states
  typedef enum logic [1:0] {ERASE_PARAM = 2'b00, ERASE_SECTOR = 2'b01, ERASE_BULK = 2'b10,
                            ERASE_NONE = 2'b11} fcb_erase_kind_e;
  typedef enum logic [0:0] {BC_IDLE = 1'b0, BC_SCAN = 1'b1} fcb_bc_state_e;
endpackage : fcb_pkg

/* hw/fcb_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Controller to blank check engine
interface fcb_erase_if;
  import fcb_pkg::*;
  logic start; // One-cycle erase request
  fcb_erase_kind_e kind; // Kind of erase
  logic bc_en; // Blank check enabled
  logic prev_ok; // Last erase of sector finished
  logic busy; // Engine scanning
  modport ctrl (output start, kind, bc_en, prev_ok, input busy);
  modport unit (input start, kind, bc_en, prev_ok, output busy);
endinterface : fcb_erase_if
// Controller to page buffer
interface fcb_buf_if;
  import fcb_pkg::*;
  logic wrap512; // Full 512-byte load window
  modport ctrl (output wrap512);
  modport unit (input wrap512);
endinterface : fcb_buf_if
`default_nettype wire

/* hw/fcb_blank_check.sv */
`timescale 1ns/1ps
`default_nettype none
module fcb_blank_check
  import fcb_pkg::*;
#(
  parameter int SCAN_W = 32 // Array scan word width
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Async reset, low
  fcb_erase_if.unit ei, // Request side
  input wire logic [SCAN_W-1:0] scan_data_i, // Array word
  input wire logic scan_valid_i, // Word valid
  input wire logic scan_last_i, // Last word of sector
  output logic scan_req_o, // Scan running
  output logic go_o, // Erase begins
  output logic skip_o // Erase skipped
);
  typedef struct packed {
    fcb_bc_state_e state;
    logic scan_req;
    logic go;
    logic skip;
  } fcb_bc_s;
  fcb_bc_s r, n;

  // Decide erase now, or scan first
  always_comb
  begin
    n = r;
    n.go = 1'b0;
    n.skip = 1'b0;
    case (r.state)
      BC_IDLE:
      begin
        if (ei.start)
        begin
          if (!ei.bc_en || ei.kind == ERASE_NONE || !ei.prev_ok)
            n.go = 1'b1;
          else
          begin
            n.state = BC_SCAN;
            n.scan_req = 1'b1;
          end
        end
      end
      BC_SCAN:
      begin
        if (scan_valid_i)
        begin
          // Any zero bit means the sector holds data
          if (~&scan_data_i)
          begin
            n.go = 1'b1;
            n.state = BC_IDLE;
            n.scan_req = 1'b0;
          end
          else if (scan_last_i)
          begin
            n.skip = 1'b1;
            n.state = BC_IDLE;
            n.scan_req = 1'b0;
          end
        end
      end
      default:
      begin
        n.state = BC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '{state: BC_IDLE, scan_req: 1'b0, go: 1'b0, skip: 1'b0};
    else
      r <= n;
  end

  assign ei.busy = (r.state != BC_IDLE);
  assign scan_req_o = r.scan_req;
  assign go_o = r.go;
  assign skip_o = r.skip;
endmodule : fcb_blank_check
`default_nettype wire

/* hw/fcb_page_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module fcb_page_buf
  import fcb_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Async reset, low
  fcb_buf_if.unit bi, // Wrap select
  input wire logic load_start_i, // Restart load pointer
  input wire logic [PAGE_AW-1:0] load_base_i, // Start location
  input wire logic load_valid_i, // Data byte valid
  input wire logic [7:0] load_data_i, // Data byte
  input wire logic rd_en_i, // Read strobe
  input wire logic [PAGE_AW-1:0] rd_addr_i, // Read location
  output logic [7:0] rd_data_o, // Read byte, registered
  output logic [PAGE_AW-1:0] load_addr_o // Next load location
);
  typedef struct packed {
    logic [PAGE_AW-1:0] addr;
    logic [7:0] rd_data;
  } fcb_buf_s;
  fcb_buf_s r, n;
  logic [7:0] mem [PAGE_DEPTH]; // Buffer storage, no reset needed
  logic [PAGE_AW-1:0] wa; // Location written this cycle

  // Pointer advance; narrow mode keeps the top address bit at zero
  always_comb
  begin
    n = r;
    wa = load_start_i ? load_base_i : r.addr;
    if (!bi.wrap512)
      wa[PAGE_AW-1] = 1'b0;
    n.addr = wa;
    if (load_valid_i)
    begin
      if (bi.wrap512)
        n.addr = wa + PAGE_AW'(1);
      else
        n.addr = {1'b0, wa[PAGE_AW-2:0] + (PAGE_AW-1)'(1)};
    end
    if (rd_en_i)
      n.rd_data = mem[rd_addr_i];
  end

  // Storage write
  always_ff @(posedge clk_i)
  begin
    if (load_valid_i)
      mem[wa] <= load_data_i;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= n;
  end

  assign rd_data_o = r.rd_data;
  assign load_addr_o = r.addr;
endmodule : fcb_page_buf
`default_nettype wire

/* hw/fcb_top.sv */
// Operation
// - Both copies reached only by 65h/71h
// - Any reset reloads working copy from boot
// - Boot bits default 0, flip once
// - Working copy rewritable, governs until reload
// - Bit 5 off: erase starts unconditionally
// - Failed previous erase: erase without checking
// - Scan sector; zero found erases, else skip
// - Check covers parameter, sector, bulk erase
// - Bit 4 selects 512 or 256 wrap
// - Narrow mode wraps past 255 to zero
// - Bit 3 set gives uniform sectors
// - Small sectors overlay top or bottom
// - Working sector-map bit follows boot bit
// - Bit 2 makes 30h resume or clear
// - Bit 0 enables F0h software reset
// - 66h then 99h always resets
`timescale 1ns/1ps
`default_nettype none
module fcb_top
  import fcb_pkg::*;
#(
  parameter int SCAN_W = 32, // Array scan word width
  parameter bit PARAM_AT_TOP = 1'b0 // Small sectors at top when set
) (
  input wire logic clk_i, // Clock, 200 MHz
  input wire logic rst_n_i, // Power-on reset, async, low
  input wire logic hw_reset_i, // Hardware reset request pulse
  input wire logic cmd_valid_i, // Decoded instruction strobe
  input wire logic [7:0] cmd_op_i, // Instruction code
  input wire logic [ADDR_W-1:0] cmd_addr_i, // Register address
  input wire logic [7:0] cmd_wdata_i, // Register write data
  output logic [7:0] rd_data_o, // Register read data
  output logic rd_valid_o, // Read data valid pulse
  output logic soft_reset_o, // Software reset pulse
  output logic resume_o, // Program/erase resume pulse
  output logic clear_status_o, // Clear status pulse
  output logic [7:0] cfg_live_o, // Working copy
  output logic hybrid_map_o, // Small sectors present
  output logic param_top_o, // Small sectors at top
  input wire logic erase_req_i, // Erase command pulse
  input wire logic [1:0] erase_kind_i, // Erase kind
  input wire logic erase_prev_ok_i, // Last erase of sector finished
  output logic erase_start_o, // Erase begins pulse
  output logic erase_skip_o, // Erase skipped, sector blank
  output logic erase_reject_o, // Erase refused pulse
  output logic scan_req_o, // Blank scan running
  input wire logic [SCAN_W-1:0] scan_data_i, // Scanned word
  input wire logic scan_valid_i, // Scanned word valid
  input wire logic scan_last_i, // Last word of sector
  input wire logic load_start_i, // Page load restart
  input wire logic [PAGE_AW-1:0] load_base_i, // Page load start
  input wire logic load_valid_i, // Page byte valid
  input wire logic [7:0] load_data_i, // Page byte
  output logic [PAGE_AW-1:0] load_addr_o, // Next page location
  input wire logic buf_rd_en_i, // Page read strobe
  input wire logic [PAGE_AW-1:0] buf_rd_addr_i, // Page read location
  output logic [7:0] buf_rd_data_o // Page read byte
);
  // All controller state in one record
  typedef struct packed {
    logic [7:0] nv; // Boot copy
    logic [7:0] v; // Working copy
    logic [7:0] rd_data; // Read answer
    logic rd_valid; // Read answer strobe
    logic armed; // Reset enable seen
    logic soft_reset; // Reset pulse
    logic resume; // Resume pulse
    logic clr; // Clear status pulse
    logic rej; // Erase refused
    logic hybrid; // Small sectors present
    logic top; // Overlay at top
  } fcb_top_s;
  fcb_top_s r, n;

  fcb_erase_if eif ();
  fcb_buf_if bif ();

  logic reload; // Working copy reload this cycle
  logic erase_ok; // Erase request accepted
  fcb_erase_kind_e kind; // Typed erase kind

  // Erase gating
  always_comb
  begin
    kind = fcb_erase_kind_e'(erase_kind_i);
    erase_ok = erase_req_i && !eif.busy;
    // 4 KB erase has no target in the uniform map
    if (kind == ERASE_PARAM && r.v[BIT_SMALL])
      erase_ok = 1'b0;
  end

  // Engine requests; blank check reads the working copy
  assign eif.start = erase_ok;
  assign eif.kind = kind;
  assign eif.bc_en = r.v[BIT_BLANK];
  assign eif.prev_ok = erase_prev_ok_i;
  assign bif.wrap512 = r.v[BIT_WRAP];

  // Command decode and register update
  always_comb
  begin
    n = r;
    n.rd_valid = 1'b0;
    n.soft_reset = 1'b0;
    n.resume = 1'b0;
    n.clr = 1'b0;
    n.rej = erase_req_i && !erase_ok;
    reload = hw_reset_i;
    if (cmd_valid_i)
    begin
      // Any instruction other than 66h breaks the reset pair
      n.armed = 1'b0;
      if (cmd_op_i == OP_READ_ANY)
      begin
        n.rd_valid = 1'b1;
        if (cmd_addr_i == ADDR_CFG_NV)
          n.rd_data = r.nv & CFG_USED_MASK;
        else if (cmd_addr_i == ADDR_CFG_V)
          n.rd_data = r.v & CFG_USED_MASK;
        else
          n.rd_data = 8'h00; // Unmapped reads zero
      end
      else if (cmd_op_i == OP_WRITE_ANY)
      begin
        if (cmd_addr_i == ADDR_CFG_NV)
        begin
          // One-time bits: a one can be set, never cleared again
          n.nv = r.nv | (cmd_wdata_i & CFG_USED_MASK);
        end
        else if (cmd_addr_i == ADDR_CFG_V)
        begin
          // Sector-map and reserved bits keep their value
          n.v = (cmd_wdata_i & V_WRITE_MASK) | (r.v & ~V_WRITE_MASK);
        end
      end
      else if (cmd_op_i == OP_RESUME_OR_CLR)
      begin
        if (r.v[BIT_RESUME])
          n.resume = 1'b1;
        else
          n.clr = 1'b1;
      end
      else if (cmd_op_i == OP_LEGACY_RST)
      begin
        if (r.v[BIT_LEGACY])
        begin
          reload = 1'b1;
          n.soft_reset = 1'b1;
        end
      end
      else if (cmd_op_i == OP_RST_ENABLE)
      begin
        n.armed = 1'b1;
      end
      else if (cmd_op_i == OP_RST_EXEC)
      begin
        // Independent of the legacy bit
        if (r.armed)
        begin
          reload = 1'b1;
          n.soft_reset = 1'b1;
        end
      end
    end
    if (reload)
      n.v = n.nv & CFG_USED_MASK;
    // Sector map always mirrors the boot bit
    n.v[BIT_SMALL] = n.nv[BIT_SMALL];
    n.hybrid = !n.v[BIT_SMALL];
    // Overlay placement is fixed by build option
    n.top = PARAM_AT_TOP;
  end

  // State register; power-on gives factory defaults in both copies
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r <= '0;
      r.nv <= NV_RESET;
      r.v <= NV_RESET;
      r.hybrid <= 1'b1;
    end
    else
      r <= n;
  end

  // Blank check sequencer
  fcb_blank_check #(
    .SCAN_W(SCAN_W)
  ) u_bc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ei(eif.unit),
    .scan_data_i(scan_data_i),
    .scan_valid_i(scan_valid_i),
    .scan_last_i(scan_last_i),
    .scan_req_o(scan_req_o),
    .go_o(erase_start_o),
    .skip_o(erase_skip_o)
  );

  // Page program buffer
  fcb_page_buf u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .bi(bif.unit),
    .load_start_i(load_start_i),
    .load_base_i(load_base_i),
    .load_valid_i(load_valid_i),
    .load_data_i(load_data_i),
    .rd_en_i(buf_rd_en_i),
    .rd_addr_i(buf_rd_addr_i),
    .rd_data_o(buf_rd_data_o),
    .load_addr_o(load_addr_o)
  );

  // Registered outputs
  assign rd_data_o = r.rd_data;
  assign rd_valid_o = r.rd_valid;
  assign soft_reset_o = r.soft_reset;
  assign resume_o = r.resume;
  assign clear_status_o = r.clr;
  assign cfg_live_o = r.v;
  assign hybrid_map_o = r.hybrid;
  assign param_top_o = r.top;
  assign erase_reject_o = r.rej;
endmodule : fcb_top
`default_nettype wire

/* verif/fcb_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module fcb_top_assertions
  import fcb_pkg::*;
#(
  parameter int SCAN_W = 32 // Scan word width
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, low
  input wire logic cmd_valid_i, // Command strobe
  input wire logic [7:0] cmd_op_i, // Command code
  input wire logic [7:0] cfg_live_o, // Working copy
  input wire logic rd_valid_o, // Read answer
  input wire logic soft_reset_o, // Soft reset
  input wire logic resume_o, // Resume pulse
  input wire logic clear_status_o, // Clear pulse
  input wire logic erase_req_i, // Erase request
  input wire logic [1:0] erase_kind_i, // Erase kind
  input wire logic erase_prev_ok_i, // Prior erase ok
  input wire logic erase_start_o, // Erase begins
  input wire logic erase_skip_o, // Erase skipped
  input wire logic scan_req_o, // Scan running
  input wire logic [SCAN_W-1:0] scan_data_i, // Scan word
  input wire logic scan_valid_i, // Scan valid
  input wire logic scan_last_i, // Last word
  input wire logic load_valid_i, // Page byte valid
  input wire logic [PAGE_AW-1:0] load_addr_o // Next load place
);
  // One clock domain, so one clocking and one disable serve all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  read_answer_a: assert property (cmd_valid_i && cmd_op_i == OP_READ_ANY |=> rd_valid_o)
    else $error("read got no answer");
  reserved_zero_a: assert property ((cfg_live_o & ~CFG_USED_MASK) == 8'h00)
    else $error("reserved bit set");
  legacy_off_a: assert property (cmd_valid_i && cmd_op_i == OP_LEGACY_RST && !cfg_live_o[BIT_LEGACY]
    |=> !soft_reset_o) else $error("legacy reset not ignored");
  legacy_on_a: assert property (cmd_valid_i && cmd_op_i == OP_LEGACY_RST && cfg_live_o[BIT_LEGACY]
    |=> soft_reset_o) else $error("legacy reset missed");
  pair_reset_a: assert property ((cmd_valid_i && cmd_op_i == OP_RST_ENABLE) ##1
    (cmd_valid_i && cmd_op_i == OP_RST_EXEC) |=> soft_reset_o) else $error("pair reset missed");
  resume_sel_a: assert property (cmd_valid_i && cmd_op_i == OP_RESUME_OR_CLR |=>
    resume_o == $past(cfg_live_o[BIT_RESUME]) && clear_status_o != $past(cfg_live_o[BIT_RESUME]))
    else $error("30h decoded wrongly");
  plain_erase_a: assert property (erase_req_i && !scan_req_o && !cfg_live_o[BIT_BLANK] &&
    erase_kind_i == 2'b01 |=> erase_start_o) else $error("unchecked erase did not start");
  failed_prev_a: assert property (erase_req_i && !scan_req_o && !erase_prev_ok_i &&
    erase_kind_i == 2'b01 |=> erase_start_o) else $error("failed sector not erased");
  bulk_scan_a: assert property (erase_req_i && !scan_req_o && cfg_live_o[BIT_BLANK] &&
    erase_prev_ok_i && erase_kind_i == 2'b10 |=> scan_req_o && !erase_start_o) else $error("no scan");
  skip_blank_a: assert property (scan_req_o && scan_valid_i && scan_last_i && (&scan_data_i)
    |=> erase_skip_o && !erase_start_o && !scan_req_o) else $error("blank sector not skipped");
  narrow_wrap_a: assert property (load_valid_i && !cfg_live_o[BIT_WRAP]
    |=> !load_addr_o[PAGE_AW-1]) else $error("load passed 255");
  // Main scenarios reached
  cover property (erase_skip_o);
  cover property (soft_reset_o);
  cover property (resume_o);
endmodule : fcb_top_assertions
bind fcb_top fcb_top_assertions #(.SCAN_W(SCAN_W)) fcb_top_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cfg_live_o(cfg_live_o), .rd_valid_o(rd_valid_o),
  .soft_reset_o(soft_reset_o), .resume_o(resume_o), .clear_status_o(clear_status_o),
  .erase_req_i(erase_req_i), .erase_kind_i(erase_kind_i), .erase_prev_ok_i(erase_prev_ok_i),
  .erase_start_o(erase_start_o), .erase_skip_o(erase_skip_o), .scan_req_o(scan_req_o),
  .scan_data_i(scan_data_i), .scan_valid_i(scan_valid_i), .scan_last_i(scan_last_i),
  .load_valid_i(load_valid_i), .load_addr_o(load_addr_o));
`default_nettype wire

/* verif/fcb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcb_host_model
  import fcb_pkg::*;
(
  input wire logic clk_i, // Clock
  output logic cmd_valid_o = 1'b0, // Command strobe
  output logic [7:0] cmd_op_o = 8'h00, // Command code
  output logic [ADDR_W-1:0] cmd_addr_o = 24'h000000, // Register address
  output logic [7:0] cmd_wdata_o = 8'h00, // Write byte
  input wire logic rd_valid_i, // Read answer valid
  input wire logic [7:0] rd_data_i // Read answer
);
  // One command; released lines show the inverse so stale values never look valid
  task send(input logic [7:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] w);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op;
    cmd_addr_o <= a;
    cmd_wdata_o <= w;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_op_o <= ~op;
    cmd_addr_o <= ~a;
    cmd_wdata_o <= ~w;
    #1;
  endtask : send
  // Two commands on consecutive edges, nothing between them
  task pair(input logic [7:0] op_a, input logic [7:0] op_b);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op_a;
    @(posedge clk_i);
    cmd_op_o <= op_b;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_op_o <= ~op_b;
    #1;
  endtask : pair
  // Register read; answer is settled just after the taking edge
  task read(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic v);
    send(OP_READ_ANY, a, 8'h00);
    d = rd_data_i;
    v = rd_valid_i;
  endtask : read
endmodule : fcb_host_model
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fcb_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, hw_reset_i = 1'b0, erase_req_i = 1'b0, erase_prev_ok_i = 1'b0;
  logic scan_valid_i = 1'b0, scan_last_i = 1'b0, load_start_i = 1'b0, load_valid_i = 1'b0, buf_rd_en_i = 1'b0;
  logic [1:0] erase_kind_i = 2'b11; // Idle kind
  logic [31:0] scan_data_i = 32'h00000000; // Scan word
  logic [8:0] load_base_i = 9'h000, buf_rd_addr_i = 9'h000; // Page places
  logic [7:0] load_data_i = 8'h00, d; // Page byte, read byte
  logic v, cmd_valid, rd_valid_o, soft_reset_o, resume_o, clear_status_o, hybrid_map_o, start_o, skip_o, rej_o;
  logic scan_o, top_o; // Scan running, overlay placement
  logic [7:0] cmd_op, cmd_wdata, rd_data_o, cfg_live_o, buf_rd_data_o; // Port values
  logic [23:0] cmd_addr; // Register address
  logic [8:0] load_addr_o; // Next load place
  int mismatches = 0, checked = 0; // Counters
  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  fcb_host_model fcb_host_model_i (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op),
    .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o));
  fcb_top fcb_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .hw_reset_i(hw_reset_i), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .soft_reset_o(soft_reset_o), .resume_o(resume_o), .clear_status_o(clear_status_o),
    .cfg_live_o(cfg_live_o), .hybrid_map_o(hybrid_map_o), .param_top_o(top_o), .erase_req_i(erase_req_i),
    .erase_kind_i(erase_kind_i), .erase_prev_ok_i(erase_prev_ok_i), .erase_start_o(start_o),
    .erase_skip_o(skip_o), .erase_reject_o(rej_o), .scan_req_o(scan_o), .scan_data_i(scan_data_i),
    .scan_valid_i(scan_valid_i), .scan_last_i(scan_last_i), .load_start_i(load_start_i),
    .load_base_i(load_base_i), .load_valid_i(load_valid_i), .load_data_i(load_data_i),
    .load_addr_o(load_addr_o), .buf_rd_en_i(buf_rd_en_i), .buf_rd_addr_i(buf_rd_addr_i),
    .buf_rd_data_o(buf_rd_data_o));
  // Single comparison point
  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Register read with expected byte
  task rd(input logic [23:0] a, input logic [7:0] e);
    fcb_host_model_i.read(a, d, v);
    chk("rd_valid", v, 1'b1);
    chk("rd_data", d, e);
  endtask : rd
  // Erase request; kind returns to the idle code once taken
  task erase(input logic [1:0] k, input logic ok);
    @(posedge clk_i);
    erase_req_i <= 1'b1;
    erase_kind_i <= k;
    erase_prev_ok_i <= ok;
    @(posedge clk_i);
    erase_req_i <= 1'b0;
    erase_kind_i <= 2'b11;
    #1;
  endtask : erase
  // One scanned word from the array side
  task scan(input logic [31:0] w, input logic last);
    @(posedge clk_i);
    scan_valid_i <= 1'b1;
    scan_data_i <= w;
    scan_last_i <= last;
    @(posedge clk_i);
    scan_valid_i <= 1'b0;
    scan_data_i <= ~w;
    scan_last_i <= 1'b0;
    #1;
  endtask : scan
  // One page byte
  task load(input logic st, input logic [8:0] b, input logic [7:0] x);
    @(posedge clk_i);
    load_valid_i <= 1'b1;
    load_start_i <= st;
    load_base_i <= b;
    load_data_i <= x;
    @(posedge clk_i);
    load_valid_i <= 1'b0;
    load_start_i <= 1'b0;
    #1;
  endtask : load
  // Closing point of the run
  task give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // Whole run is under a hundred cycles, so this only fires on a hang
  initial
  begin
    #20000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("cfg_live", cfg_live_o, 8'h00);
    chk("hybrid", hybrid_map_o, 1'b1);
    chk("param_top", top_o, 1'b0);
    rd(ADDR_CFG_NV, 8'h00);
    rd(24'h000005, 8'h00);
    $display("reset test done");
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_V, 8'hF7);
    rd(ADDR_CFG_V, 8'h35);
    fcb_host_model_i.send(OP_RESUME_OR_CLR, 24'h0, 8'h00);
    chk("resume", resume_o, 1'b1);
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_V, 8'h20);
    fcb_host_model_i.send(OP_RESUME_OR_CLR, 24'h0, 8'h00);
    chk("clear", clear_status_o, 1'b1);
    erase(2'b00, 1'b1);
    scan(32'hFFFFFFFF, 1'b1);
    chk("skip", skip_o, 1'b1);
    $display("working copy test done");
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_NV, 8'h29);
    chk("hybrid", hybrid_map_o, 1'b0);
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_NV, 8'h00);
    rd(ADDR_CFG_NV, 8'h29);
    @(posedge clk_i);
    hw_reset_i <= 1'b1;
    @(posedge clk_i);
    hw_reset_i <= 1'b0;
    #1;
    chk("cfg_live", cfg_live_o, 8'h29);
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_V, 8'h08);
    fcb_host_model_i.send(OP_LEGACY_RST, 24'h0, 8'h00);
    chk("soft_reset", soft_reset_o, 1'b0);
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_V, 8'h09);
    fcb_host_model_i.send(OP_LEGACY_RST, 24'h0, 8'h00);
    chk("soft_reset", soft_reset_o, 1'b1);
    chk("cfg_live", cfg_live_o, 8'h29);
    fcb_host_model_i.send(OP_RST_EXEC, 24'h0, 8'h00);
    chk("soft_reset", soft_reset_o, 1'b0);
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_V, 8'h08);
    fcb_host_model_i.pair(OP_RST_ENABLE, OP_RST_EXEC);
    chk("soft_reset", soft_reset_o, 1'b1);
    $display("reset path test done");
    erase(2'b00, 1'b1);
    chk("reject", rej_o, 1'b1);
    erase(2'b01, 1'b1);
    chk("scan_req", scan_o, 1'b1);
    // A second request while the sector is being scanned is refused
    erase(2'b01, 1'b1);
    chk("reject", rej_o, 1'b1);
    scan(32'hFFFFFFFF, 1'b0);
    scan(32'hFFFFFFFF, 1'b1);
    chk("skip", skip_o, 1'b1);
    chk("start", start_o, 1'b0);
    chk("scan_req", scan_o, 1'b0);
    erase(2'b10, 1'b1);
    scan(32'hFFFFFFEF, 1'b0);
    chk("start", start_o, 1'b1);
    erase(2'b01, 1'b0);
    chk("start", start_o, 1'b1);
    // Idle erase kind never scans, even with the check on
    erase(2'b11, 1'b1);
    chk("start", start_o, 1'b1);
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_V, 8'h08);
    erase(2'b01, 1'b1);
    chk("start", start_o, 1'b1);
    $display("erase test done");
    load(1'b1, 9'h0FF, 8'hA5);
    chk("load_addr", load_addr_o, 9'h000);
    load(1'b0, 9'h000, 8'h5A);
    @(posedge clk_i);
    buf_rd_en_i <= 1'b1;
    @(posedge clk_i);
    buf_rd_en_i <= 1'b0;
    #1;
    chk("buf_data", buf_rd_data_o, 8'h5A);
    fcb_host_model_i.send(OP_WRITE_ANY, ADDR_CFG_V, 8'h18);
    load(1'b1, 9'h0FF, 8'hA5);
    chk("load_addr", load_addr_o, 9'h100);
    $display("page buffer test done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
